/* rtl/agd_regs.sv */
`timescale 1ns/100ps
module agd_regs
(
    input  wire logic        clk,                   // core clock, 200 MHz
    input  wire logic        arst_n,                // async reset, active low
    input  wire logic [7:0]  reg_addr,              // register offset
    input  wire logic        reg_wr,                // write strobe
    input  wire logic [7:0]  reg_wdata,             // write data
    input  wire logic        reg_rd,                // read strobe
    output logic      [7:0]  reg_rdata,             // read data, valid after reg_rd
    input  wire logic        double_rate_audio_mode,// double rate audio on
    input  wire logic        lft_gain_vld,          // left gain loop update
    input  wire logic [7:0]  lft_gain_in,           // left gain from loop
    input  wire logic        rgt_gain_vld,          // right gain loop update
    input  wire logic [7:0]  rgt_gain_in,           // right gain from loop
    output logic      [2:0]  rgt_hyst_db,           // right hysteresis in dB
    output logic             rgt_hyst_en,           // right hysteresis active
    output logic             rgt_noise_det_en,      // right noise detection on
    output logic      [6:0]  rgt_noise_thr_db,      // right threshold, dB below 0
    output logic             rgt_clip_step_en,      // right clip stepping on
    output logic      [11:0] lft_noise_db_ticks,    // left noise debounce, 0.5 ms
    output logic      [11:0] lft_sig_db_ticks,      // left signal debounce, 0.5 ms
    output logic      [11:0] rgt_noise_db_ticks,    // right noise debounce, 0.5 ms
    output logic      [11:0] rgt_sig_db_ticks       // right signal debounce, 0.5 ms
);
    import agd_pkg::*;

    typedef struct packed {
        logic [7:0] gate_cfg;
        logic [7:0] lft_gain;
        logic [7:0] rgt_gain;
        logic [7:0] lft_deb;
        logic [7:0] rgt_deb;
        logic [7:0] rdata;
        logic [2:0] hyst_db;
        logic       hyst_en;
        logic       noise_en;
        logic [6:0] thr_db;
        logic       clip_en;
    } agd_state_t;

    agd_state_t st_r;
    agd_state_t st_nxt;

    logic [1:0] hyst_code;
    logic [4:0] thr_code;

    // clamp a loop value into the reportable window
    function automatic logic [7:0] clamp_gain(input logic [7:0] g);
        logic signed [7:0] s;
        s = signed'(g);
        if (s < GAIN_MIN)
            return GAIN_MIN;
        else if (s > GAIN_MAX)
            return GAIN_MAX;
        return g;
    endfunction

    always_comb
    begin
        st_nxt = st_r;
        // writes land first so decoded fields follow within one more cycle
        if (reg_wr)
        begin
            case (reg_addr)
                OFS_RGT_GATE_CFG: st_nxt.gate_cfg = reg_wdata;
                OFS_LFT_DEBOUNCE: st_nxt.lft_deb  = reg_wdata;
                OFS_RGT_DEBOUNCE: st_nxt.rgt_deb  = reg_wdata;
                default:          st_nxt.gate_cfg = st_r.gate_cfg;
            endcase
        end
        // gain registers ignore writes; only the loop moves them
        if (lft_gain_vld)
            st_nxt.lft_gain = clamp_gain(lft_gain_in);
        if (rgt_gain_vld)
            st_nxt.rgt_gain = clamp_gain(rgt_gain_in);

        if (reg_rd)
        begin
            case (reg_addr)
                OFS_RGT_GATE_CFG: st_nxt.rdata = st_r.gate_cfg;
                OFS_LFT_GAIN:     st_nxt.rdata = st_r.lft_gain;
                OFS_RGT_GAIN:     st_nxt.rdata = st_r.rgt_gain;
                OFS_LFT_DEBOUNCE: st_nxt.rdata = st_r.lft_deb;
                OFS_RGT_DEBOUNCE: st_nxt.rdata = st_r.rgt_deb;
                default:          st_nxt.rdata = RST_RD_DATA;
            endcase
        end

        hyst_code = st_r.gate_cfg[HYST_MSB:HYST_LSB];
        thr_code  = st_r.gate_cfg[THR_MSB:THR_LSB];
        st_nxt.hyst_en = (hyst_code != HYST_OFF);
        case (hyst_code)
            2'h0:    st_nxt.hyst_db = 3'h1;
            2'h1:    st_nxt.hyst_db = 3'h2;
            2'h2:    st_nxt.hyst_db = 3'h4;
            default: st_nxt.hyst_db = 3'h0;
        endcase
        st_nxt.noise_en = (thr_code != THR_DISABLED);
        if (thr_code == THR_DISABLED)
            st_nxt.thr_db = 7'h00;
        else
            st_nxt.thr_db = THR_BASE_DB + 7'(thr_code) * THR_STEP_DB;
        st_nxt.clip_en = st_r.gate_cfg[CLIP_BIT];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r          <= '0;
            st_r.gate_cfg <= RST_GATE_CFG;
            st_r.lft_gain <= RST_GAIN;
            st_r.rgt_gain <= RST_GAIN;
            st_r.lft_deb  <= RST_DEBOUNCE;
            st_r.rgt_deb  <= RST_DEBOUNCE;
            st_r.rdata    <= RST_RD_DATA;
            st_r.hyst_db  <= RST_HYST_DB;
            st_r.hyst_en  <= RST_HYST_EN;
        end
        else
            st_r <= st_nxt;
    end

    agd_debounce_dec u_lft_deb
    (
        .clk          (clk),
        .arst_n       (arst_n),
        .cfg                    (st_r.lft_deb),
        .double_rate_audio_mode (double_rate_audio_mode),
        .noise_ticks  (lft_noise_db_ticks),
        .signal_ticks (lft_sig_db_ticks)
    );

    // same decode as the left side
    agd_debounce_dec u_rgt_deb
    (
        .clk          (clk),
        .arst_n       (arst_n),
        .cfg                    (st_r.rgt_deb),
        .double_rate_audio_mode (double_rate_audio_mode),
        .noise_ticks  (rgt_noise_db_ticks),
        .signal_ticks (rgt_sig_db_ticks)
    );

    assign reg_rdata        = st_r.rdata;
    assign rgt_hyst_db      = st_r.hyst_db;
    assign rgt_hyst_en      = st_r.hyst_en;
    assign rgt_noise_det_en = st_r.noise_en;
    assign rgt_noise_thr_db = st_r.thr_db;
    assign rgt_clip_step_en = st_r.clip_en;
endmodule // agd_regs

/* rtl/agd_pkg.sv */
package agd_pkg;
    // register offsets on the internal control port
    localparam logic [7:0] OFS_RGT_GATE_CFG = 8'h1f;
    localparam logic [7:0] OFS_LFT_GAIN     = 8'h20;
    localparam logic [7:0] OFS_RGT_GAIN     = 8'h21;
    localparam logic [7:0] OFS_LFT_DEBOUNCE = 8'h22;
    localparam logic [7:0] OFS_RGT_DEBOUNCE = 8'h23;

    // reset values
    localparam logic [7:0] RST_GATE_CFG = 8'h00;
    localparam logic [7:0] RST_GAIN     = 8'h00;
    localparam logic [7:0] RST_DEBOUNCE = 8'h00;
    localparam logic [7:0] RST_RD_DATA  = 8'h00;
    // hysteresis code 00 after reset decodes to 1 dB, active
    localparam logic [2:0] RST_HYST_DB  = 3'h1;
    localparam logic       RST_HYST_EN  = 1'h1;

    // gate config fields
    localparam int HYST_MSB   = 7;
    localparam int HYST_LSB   = 6;
    localparam int THR_MSB    = 5;
    localparam int THR_LSB    = 1;
    localparam int CLIP_BIT   = 0;
    localparam logic [1:0] HYST_OFF = 2'h3;
    localparam logic [4:0] THR_DISABLED = 5'h00;
    // threshold attenuation in dB = THR_BASE_DB + THR_STEP_DB * code
    localparam logic [6:0] THR_BASE_DB = 7'h1c;
    localparam logic [6:0] THR_STEP_DB = 7'h02;

    // debounce fields
    localparam int NOISE_MSB  = 7;
    localparam int NOISE_LSB  = 3;
    localparam int SIG_MSB    = 2;
    localparam int SIG_LSB    = 0;
    // first code of the 64 ms multiples and its offset
    localparam logic [4:0] NOISE_LIN_CODE = 5'h08;
    localparam logic [4:0] NOISE_LIN_OFS  = 5'h07;
    localparam logic [4:0] NOISE_POW_CODE = 5'h02;
    // 64 ms expressed in 0.5 ms ticks
    localparam logic [7:0] NOISE_LIN_TICKS = 8'h80;
    localparam logic [11:0] RST_TICKS = 12'h000;

    // applied gain limits, two's complement 0.5 dB steps
    localparam logic signed [7:0] GAIN_MIN = 8'he8;
    localparam logic signed [7:0] GAIN_MAX = 8'h77;
endpackage

/* rtl/agd_debounce_dec.sv */
`timescale 1ns/100ps
module agd_debounce_dec
(
    input  wire logic        clk,          // core clock
    input  wire logic        arst_n,       // async reset, active low
    input  wire logic [7:0]  cfg,          // debounce register contents
    input  wire logic        double_rate_audio_mode, // double rate audio mode on
    output logic      [11:0] noise_ticks,  // noise debounce in 0.5 ms ticks
    output logic      [11:0] signal_ticks  // signal debounce in 0.5 ms ticks
);
    import agd_pkg::*;

    typedef struct packed {
        logic [11:0] noise;
        logic [11:0] sig;
    } agd_dec_state_t;

    agd_dec_state_t st_r;
    agd_dec_state_t st_nxt;

    logic [4:0] ncode;
    logic [2:0] scode;
    logic [4:0] nmul;

    always_comb
    begin
        ncode  = cfg[NOISE_MSB:NOISE_LSB];
        scode  = cfg[SIG_MSB:SIG_LSB];
        nmul   = ncode - NOISE_LIN_OFS;
        st_nxt = st_r;
        // code 1 has no defined time; treated as zero like code 0
        if (ncode >= NOISE_LIN_CODE)
            // widen before the product; 24 * 128 overflows eight bits
            st_nxt.noise = 12'(nmul) * 12'(NOISE_LIN_TICKS);
        else if (ncode >= NOISE_POW_CODE)
            st_nxt.noise = 12'h002 << (ncode - NOISE_POW_CODE);
        else
            st_nxt.noise = RST_TICKS;
        if (scode == 3'h0)
            st_nxt.sig = RST_TICKS;
        else
            st_nxt.sig = 12'h001 << (scode - 3'h1);
        // sample rate doubles, so the hardware counts expire twice as fast
        if (double_rate_audio_mode)
        begin
            st_nxt.noise = st_nxt.noise >> 1;
            st_nxt.sig   = st_nxt.sig >> 1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            st_r <= '{noise: RST_TICKS, sig: RST_TICKS};
        else
            st_r <= st_nxt;
    end

    assign noise_ticks  = st_r.noise;
    assign signal_ticks = st_r.sig;
endmodule // agd_debounce_dec

/* bench/agd_regs_properties.sv */
`timescale 1ns/100ps
module agd_regs_properties
(
    input wire logic        clk,                    // clock
    input wire logic        arst_n,                 // reset
    input wire logic [7:0]  reg_addr,               // offset
    input wire logic        reg_wr,                 // write
    input wire logic [7:0]  reg_wdata,              // write data
    input wire logic        reg_rd,                 // read
    input wire logic [7:0]  reg_rdata,              // read data
    input wire logic        double_rate_audio_mode, // rate mode
    input wire logic        rgt_hyst_en,            // hysteresis on
    input wire logic [2:0]  rgt_hyst_db,            // hysteresis dB
    input wire logic        rgt_noise_det_en,       // detection on
    input wire logic [6:0]  rgt_noise_thr_db,       // threshold dB
    input wire logic        rgt_clip_step_en,       // clip stepping
    input wire logic [11:0] lft_noise_db_ticks,     // noise debounce
    input wire logic [11:0] lft_sig_db_ticks        // signal debounce
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    function automatic logic [11:0] noise_t(logic [4:0] c);
        return c < 2 ? 12'h000 : c < 8 ? 12'(1 << (c - 1)) : 12'(128 * (c - 7));
    endfunction
    sequence gate_wr;
        reg_wr && reg_addr == 8'h1f;
    endsequence
    // decode flop samples the rate mode one edge after the write
    sequence dbc_wr;
        reg_wr && reg_addr == 8'h22 ##1 !double_rate_audio_mode;
    endsequence
    a_hyst_off: assert property (gate_wr ##0 reg_wdata[7:6] == 2'h3 |=> ##1
        !rgt_hyst_en && rgt_hyst_db == 3'h0) else $error("hysteresis not off");
    a_hyst_step: assert property (gate_wr ##0 reg_wdata[7:6] != 2'h3 |=> ##1
        rgt_hyst_en && rgt_hyst_db == 3'(1 << $past(reg_wdata[7:6], 2)))
        else $error("hysteresis step wrong");
    a_thr_off: assert property (gate_wr ##0 reg_wdata[5:1] == 5'h00 |=> ##1
        !rgt_noise_det_en) else $error("detection not off");
    a_thr_level: assert property (gate_wr ##0 reg_wdata[5:1] != 5'h00 |=> ##1
        rgt_noise_det_en && rgt_noise_thr_db == 7'(28 + 2 * $past(reg_wdata[5:1], 2)))
        else $error("threshold wrong");
    a_clip_bit: assert property (gate_wr |=> ##1
        rgt_clip_step_en == $past(reg_wdata[0], 2)) else $error("clip stepping wrong");
    a_noise_dbc: assert property (dbc_wr |=>
        lft_noise_db_ticks == noise_t($past(reg_wdata[7:3], 2))) else $error("noise ticks");
    a_sig_dbc: assert property (dbc_wr |=> lft_sig_db_ticks ==
        ($past(reg_wdata[2:0], 2) == 3'h0 ? 12'h000 : 12'(1 << ($past(reg_wdata[2:0], 2) - 1))))
        else $error("signal ticks");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_gain_range: assert property (reg_rd && reg_addr inside {8'h20, 8'h21} |=>
        $signed(reg_rdata) >= -24 && $signed(reg_rdata) <= 119) else $error("gain out of range");
endmodule // agd_regs_properties
bind agd_regs agd_regs_properties u_props
(
    .clk                    (clk),
    .arst_n                 (arst_n),
    .reg_addr               (reg_addr),
    .reg_wr                 (reg_wr),
    .reg_wdata              (reg_wdata),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .double_rate_audio_mode (double_rate_audio_mode),
    .rgt_hyst_en            (rgt_hyst_en),
    .rgt_hyst_db            (rgt_hyst_db),
    .rgt_noise_det_en       (rgt_noise_det_en),
    .rgt_noise_thr_db       (rgt_noise_thr_db),
    .rgt_clip_step_en       (rgt_clip_step_en),
    .lft_noise_db_ticks     (lft_noise_db_ticks),
    .lft_sig_db_ticks       (lft_sig_db_ticks)
);

/* bench/agd_regs_tb_top.sv */
`timescale 1ns/100ps
module agd_regs_tb_top;
    import agd_pkg::*;
    logic        clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, double_rate_audio_mode = 0;
    logic        lft_gain_vld = 0, rgt_gain_vld = 0, rgt_hyst_en, rgt_noise_det_en;
    logic        rgt_clip_step_en;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, lft_gain_in = 8'h00, rgt_gain_in = 8'h00;
    logic [7:0]  reg_rdata, d, m[31:35] = '{default: 8'h00};
    logic [7:0]  gv[6] = '{8'h80, 8'h7f, 8'he7, 8'he8, 8'h77, 8'h78};
    logic [2:0]  rgt_hyst_db;
    logic [6:0]  rgt_noise_thr_db;
    logic [11:0] lft_noise_db_ticks, lft_sig_db_ticks, rgt_noise_db_ticks, rgt_sig_db_ticks;
    int          n_fail = 0, checks = 0, cyc = 0, seed = 32'h6e3c_f640;
    agd_regs u_dut
    (
        .clk                    (clk),
        .arst_n                 (arst_n),
        .reg_addr               (reg_addr),
        .reg_wr                 (reg_wr),
        .reg_wdata              (reg_wdata),
        .reg_rd                 (reg_rd),
        .reg_rdata              (reg_rdata),
        .double_rate_audio_mode (double_rate_audio_mode),
        .lft_gain_vld           (lft_gain_vld),
        .lft_gain_in            (lft_gain_in),
        .rgt_gain_vld           (rgt_gain_vld),
        .rgt_gain_in            (rgt_gain_in),
        .rgt_hyst_db            (rgt_hyst_db),
        .rgt_hyst_en            (rgt_hyst_en),
        .rgt_noise_det_en       (rgt_noise_det_en),
        .rgt_noise_thr_db       (rgt_noise_thr_db),
        .rgt_clip_step_en       (rgt_clip_step_en),
        .lft_noise_db_ticks     (lft_noise_db_ticks),
        .lft_sig_db_ticks       (lft_sig_db_ticks),
        .rgt_noise_db_ticks     (rgt_noise_db_ticks),
        .rgt_sig_db_ticks       (rgt_sig_db_ticks)
    );
    always #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(string nm, logic [11:0] exp, logic [11:0] got);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic int nt(logic [4:0] c);
        return (c < 2 ? 0 : c < 8 ? 1 << (c - 1) : 128 * (c - 7)) >> double_rate_audio_mode;
    endfunction
    function automatic int st(logic [2:0] c);
        return (c == 0 ? 0 : 1 << (c - 1)) >> double_rate_audio_mode;
    endfunction
    function automatic logic [7:0] clamp(logic [7:0] v);
        return $signed(v) < -24 ? 8'he8 : $signed(v) > 119 ? 8'h77 : v;
    endfunction
    task automatic wr(int a, logic [7:0] v);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, 8'(a), v};
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a inside {31, 34, 35}) m[a] = v; // gain registers ignore writes
    endtask
    task automatic rd(int a);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, 8'(a)};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", a inside {[31:35]} ? m[a] : 8'h00, reg_rdata);
    endtask
    task automatic dec();
        @(posedge clk);
        #1 chk("hyst_db", m[31][7:6] == 2'h3 ? 0 : 1 << m[31][7:6], rgt_hyst_db);
        chk("hyst_en", m[31][7:6] != 2'h3, rgt_hyst_en);
        chk("det_en", m[31][5:1] != 5'h00, rgt_noise_det_en);
        chk("thr_db", m[31][5:1] ? 28 + 2 * m[31][5:1] : 0, rgt_noise_thr_db);
        chk("clip", m[31][0], rgt_clip_step_en);
        chk("lft_noise", nt(m[34][7:3]), lft_noise_db_ticks);
        chk("lft_sig", st(m[34][2:0]), lft_sig_db_ticks);
        chk("rgt_noise", nt(m[35][7:3]), rgt_noise_db_ticks);
        chk("rgt_sig", st(m[35][2:0]), rgt_sig_db_ticks);
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        for (int a = 31; a < 37; a++) rd(a);
        dec();
        $display("test reset done");
        for (int i = 0; i < 12; i++)
        begin
            d = $random(seed);
            if (i < 4) d[7:6] = i[1:0];
            if (i < 3) d[5:1] = i == 0 ? 5'h00 : i == 1 ? 5'h01 : 5'h1f;
            wr(31, d);
            dec();
            rd(31);
        end
        $display("test gate config done");
        for (int c = 0; c < 32; c++)
        begin
            @(posedge clk) double_rate_audio_mode <= c[0];
            wr(34, {c[4:0], c[2:0]});
            wr(35, {~c[4:0], ~c[2:0]});
            dec();
            rd(34 + c[0]);
        end
        $display("test debounce done");
        for (int i = 0; i < 12; i++)
        begin
            d = i < 6 ? gv[i] : $random(seed);
            @(posedge clk);
            {lft_gain_vld, lft_gain_in, rgt_gain_vld, rgt_gain_in} <= {1'b1, d, i[0], ~d};
            @(posedge clk);
            {lft_gain_vld, rgt_gain_vld} <= 2'b00;
            m[32] = clamp(d);
            if (i[0]) m[33] = clamp(~d);
            wr(32 + i[0], 8'h55);
            rd(32);
            rd(33);
        end
        $display("test applied gain done");
        tally_and_finish();
    end
endmodule // agd_regs_tb_top
